/* rtl/adcm_regs.vh */
/*
 * register map, field positions, codes and reset values of the converter
 * control block; the rule summary of the block stands below.
 * assumes a 16-bit register port with a 5-bit word address.
 */
//
// Overview of operation
// R01: plain differential: any pin positive, negative only from pins 0 to 3.
// R02: gained differential: any pin positive, negative only from pins 4 to 7.
// R03: software must use signed mode for any differential channel.
// R04: gain stage offers 1x, 2x, 4x, 8x, 16x, 32x and 64x.
// R05: gained path samples and amplifies first, then feeds the converter.
// R06: single-ended takes any pin, in signed and unsigned mode.
// R07: signed single-ended ties the negative input to internal ground.
// R08: unsigned mode ties the negative input to half reference minus offset.
// R09: internal sources: temperature, bandgap, supply/10, dac, pad and internal ground.
// R10: software must enable an internal source before converting it.
// R11: differential negative choice also offers pad ground and internal ground.
// R12: internal signals in signed mode use internal ground as negative.
// R13: four channels, each with own control, result, event, interrupt, dma.
// R14: one shared pipeline accepts a new start every converter clock; the code takes no start on the converter clock after a gained start.
// R15: a result register changes only on its own channel's conversions.
// R16: reference from 1.00 V bandgap, supply/1.6, or either port pin.
// R17: signed or unsigned is one global setting for all channels.
// R18: signed 12-bit results span 0xF800 to 0x07FF.
// R19: unsigned 12-bit results span 0x0000 to 0x0FFF.
// R20: resolution is 8 or 12 bits; 8 bits finish sooner.
// R21: 16-bit results, right adjusted; 12-bit may be left adjusted.
// R22: signed results sign-extend from bit 11 or bit 7.
// R23: channel selection is frozen when its conversion starts.
`ifndef ADCM_REGS_VH
`define ADCM_REGS_VH
// word addresses
`define ADCM_A_CTRL      5'h00
`define ADCM_A_PRESC     5'h01
`define ADCM_A_START     5'h02
`define ADCM_A_STATUS    5'h03
`define ADCM_A_CHCTRL0   5'h04
`define ADCM_A_CHMUX0    5'h05
`define ADCM_A_RES0      5'h0C
// global control fields
`define ADCM_CTRL_EN     0
`define ADCM_CTRL_SIGNED 1
`define ADCM_CTRL_RES8   2
`define ADCM_CTRL_LEFT   3
`define ADCM_CTRL_REF    4
`define ADCM_CTRL_RST    8'h00
`define ADCM_PRESC_RST   3'h0
`define ADCM_DIV_BASE    10'h004
// channel input modes
`define ADCM_MODE_INT    2'h0
`define ADCM_MODE_SE     2'h1
`define ADCM_MODE_DIFF   2'h2
`define ADCM_MODE_DIFFG  2'h3
`define ADCM_GAIN_MAX    3'h6
// negative field of a channel: 0..3 pin in group, then grounds
`define ADCM_NEG_PADGND  3'h4
`define ADCM_NEG_INTGND  3'h5
// negative select toward the analogue mux
`define ADCM_NSEL_GRP_HI 4'h4
`define ADCM_NSEL_PADGND 4'h8
`define ADCM_NSEL_INTGND 4'h9
`define ADCM_NSEL_HALFREF 4'hA
// positive select: pins 0..15, internal sources from 0x10
`define ADCM_PSEL_INT    5'h10
`define ADCM_INT_MAX     3'h5
`endif

/* rtl/adcm_fmt.v */
/*
 * packs a raw converter code into a 16-bit result word.
 * assumes the raw code is two's complement in signed mode, plain binary
 * otherwise, with an 8-bit code in the low bits.
 */
`timescale 1ns/10ps
module adcm_fmt (
   input  wire [11:0] i_raw,
   input  wire        i_signed,
   input  wire        i_res8,
   input  wire        i_left,
   output reg  [15:0] o_word
);
   // adjust and extend; left adjust only means something at 12 bits
   always @* begin
      if (i_res8) begin
         if (i_signed) begin
            o_word = {{8{i_raw[7]}}, i_raw[7:0]}; // R22
         end else begin
            o_word = {8'h00, i_raw[7:0]}; // R20
         end
      end else if (i_left) begin
         o_word = {i_raw, 4'h0}; // R21
      end else if (i_signed) begin
         o_word = {{4{i_raw[11]}}, i_raw}; // R18 R22
      end else begin
         o_word = {4'h0, i_raw}; // R19 R21
      end
   end
endmodule

/* rtl/adcm_chan.v */
/*
 * one conversion channel: input selection, start request, frozen
 * conversion settings, result register and completion flags.
 * assumes strobes decoded by the owning block, one cycle each.
 */
`timescale 1ns/10ps
`include "adcm_regs.vh"
module adcm_chan (
   input  wire        i_clk,
   input  wire        i_rst,
   input  wire        i_wr_ctrl,
   input  wire        i_wr_mux,
   input  wire [7:0]  i_wdata,
   input  wire        i_start,
   input  wire        i_accept,
   input  wire        i_done,
   input  wire [15:0] i_res,
   input  wire        i_rd_res,
   input  wire        i_clr_flag,
   input  wire [2:0]  i_cfg,
   output reg  [1:0]  o_mode,
   output reg  [2:0]  o_gain,
   output reg  [3:0]  o_pos,
   output reg  [2:0]  o_neg,
   output reg         o_pending,
   output reg         o_busy,
   output reg         o_flag,
   output reg         o_dma,
   output reg  [2:0]  o_snap,
   output reg  [15:0] o_result
);
   // control, start bookkeeping and result; set beats clear on flags
   always @(posedge i_clk) begin
      if (i_rst) begin
         o_mode    <= `ADCM_MODE_INT;
         o_gain    <= 3'h0;
         o_pos     <= 4'h0;
         o_neg     <= 3'h0;
         o_pending <= 1'b0;
         o_busy    <= 1'b0;
         o_flag    <= 1'b0;
         o_dma     <= 1'b0;
         o_snap    <= 3'h0;
         o_result  <= 16'h0000;
      end else begin
         if (i_wr_ctrl) begin
            o_mode <= i_wdata[1:0];
            // codes above 64x fold onto the top gain
            o_gain <= (i_wdata[4:2] > `ADCM_GAIN_MAX) ? `ADCM_GAIN_MAX : i_wdata[4:2]; // R04
         end
         if (i_wr_mux) begin
            o_pos <= i_wdata[3:0];
            o_neg <= i_wdata[6:4];
         end
         o_pending <= (o_pending & ~i_accept) | i_start;
         if (i_accept) begin
            o_snap <= i_cfg; // R23
         end
         o_busy <= (o_busy & ~i_done) | i_accept;
         if (i_done) begin
            o_result <= i_res; // R15
         end
         o_flag <= i_done | (o_flag & ~i_clr_flag); // R13
         o_dma  <= i_done | (o_dma & ~i_rd_res); // R13
      end
   end
endmodule

/* rtl/adcm_top.v */
/*
 * control side of a pipelined 12-bit converter with four channels:
 * register port, converter clock prescaler, start arbitration onto the
 * shared pipeline, analogue mux and gain selection, result packing.
 * assumes the converter core returns each finished code with the channel
 * number it was started for, one finished code per reference clock.
 */
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "adcm_regs.vh"
module adcm_top (
   input  wire        i_ref_clk,
   input  wire        i_rst,
   input  wire [4:0]  i_addr,
   input  wire [15:0] i_wdata,
   input  wire        i_wr,
   input  wire        i_rd,
   output reg  [15:0] o_rdata,
   input  wire [3:0]  i_chan_trig,
   input  wire        i_core_done,
   input  wire [1:0]  i_core_chan,
   input  wire [11:0] i_core_data,
   output reg         o_core_en,
   output reg         o_conv_tick,
   output reg         o_start,
   output reg  [1:0]  o_start_chan,
   output reg  [4:0]  o_pos_sel,
   output reg  [3:0]  o_neg_sel,
   output reg         o_gain_en,
   output reg  [2:0]  o_gain_sel,
   output reg         o_res8,
   output reg         o_signed_mode,
   output reg  [1:0]  o_ref_sel,
   output reg  [3:0]  o_chan_event,
   output reg  [3:0]  o_chan_irq,
   output reg  [3:0]  o_chan_dma
);
   reg  [7:0]  ctrl_reg;
   reg  [2:0]  presc_reg;
   reg  [9:0]  div_cnt_reg;
   reg  [9:0]  div_cnt_next;
   reg         tick_next;
   reg         gain_hold_reg;
   reg  [15:0] rdata_next;
   reg  [1:0]  grant_chan;
   reg         grant_any;
   reg  [3:0]  accept_vec;
   reg  [4:0]  pos_next;
   reg  [3:0]  neg_next;
   reg  [15:0] res_word_in;
   reg  [2:0]  done_cfg;
   reg  [1:0]  rd_ch;
   wire [9:0]  div_lim;
   wire [3:0]  wr_ctrl_vec;
   wire [3:0]  wr_mux_vec;
   wire [3:0]  rd_res_vec;
   wire [3:0]  clr_vec;
   wire [3:0]  start_vec;
   wire [3:0]  done_vec;
   wire [7:0]  ch_mode;
   wire [11:0] ch_gain;
   wire [15:0] ch_pos;
   wire [11:0] ch_neg;
   wire [3:0]  ch_pend;
   wire [3:0]  ch_busy;
   wire [3:0]  ch_flag;
   wire [3:0]  ch_dma;
   wire [11:0] ch_snap;
   wire [63:0] ch_result;
   wire [2:0]  glb_cfg;
   wire        sw_start;
   wire [15:0] res_word;
   genvar      g;

   // signed, 8-bit and left-adjust as one snapshot per conversion
   assign glb_cfg  = {ctrl_reg[`ADCM_CTRL_SIGNED], ctrl_reg[`ADCM_CTRL_RES8], ctrl_reg[`ADCM_CTRL_LEFT]}; // R17
   assign sw_start = i_wr & (i_addr == `ADCM_A_START);
   assign clr_vec  = (i_wr & (i_addr == `ADCM_A_STATUS)) ? i_wdata[3:0] : 4'h0;
   // software start bits and external triggers both queue a request
   assign start_vec = (sw_start ? i_wdata[3:0] : 4'h0) | i_chan_trig;
   // the core tags each finished code, so only that channel updates
   assign done_vec = i_core_done ? (4'h1 << i_core_chan) : 4'h0; // R15
   // converter clock divides the reference clock by 4 << prescale
   assign div_lim = (`ADCM_DIV_BASE << presc_reg) - 10'h001;

   // per-channel register strobes
   generate
      for (g = 0; g < 4; g = g + 1) begin : gen_dec
         assign wr_ctrl_vec[g] = i_wr & (i_addr == `ADCM_A_CHCTRL0 + 2 * g);
         assign wr_mux_vec[g]  = i_wr & (i_addr == `ADCM_A_CHMUX0 + 2 * g);
         assign rd_res_vec[g]  = i_rd & (i_addr == `ADCM_A_RES0 + g);
      end
   endgenerate

   // four identical channels share the pipeline below
   generate
      for (g = 0; g < 4; g = g + 1) begin : gen_ch
         adcm_chan u_chan ( // R13
            .i_clk      (i_ref_clk),
            .i_rst      (i_rst),
            .i_wr_ctrl  (wr_ctrl_vec[g]),
            .i_wr_mux   (wr_mux_vec[g]),
            .i_wdata    (i_wdata[7:0]),
            .i_start    (start_vec[g]),
            .i_accept   (accept_vec[g]),
            .i_done     (done_vec[g]),
            .i_res      (res_word),
            .i_rd_res   (rd_res_vec[g]),
            .i_clr_flag (clr_vec[g]),
            .i_cfg      (glb_cfg),
            .o_mode     (ch_mode[2*g+1:2*g]),
            .o_gain     (ch_gain[3*g+2:3*g]),
            .o_pos      (ch_pos[4*g+3:4*g]),
            .o_neg      (ch_neg[3*g+2:3*g]),
            .o_pending  (ch_pend[g]),
            .o_busy     (ch_busy[g]),
            .o_flag     (ch_flag[g]),
            .o_dma      (ch_dma[g]),
            .o_snap     (ch_snap[3*g+2:3*g]),
            .o_result   (ch_result[16*g+15:16*g])
         );
      end
   endgenerate

   // settings frozen at start of the finishing channel pick the packing
   always @* begin
      done_cfg = ch_snap[3*i_core_chan +: 3];
   end

   adcm_fmt u_fmt (
      .i_raw    (i_core_data),
      .i_signed (done_cfg[2]),
      .i_res8   (done_cfg[1]),
      .i_left   (done_cfg[0]),
      .o_word   (res_word)
   );

   // converter clock prescaler
   always @* begin
      tick_next    = 1'b0;
      div_cnt_next = div_cnt_reg + 10'h001;
      if (!ctrl_reg[`ADCM_CTRL_EN]) begin
         div_cnt_next = 10'h000;
      end else if (div_cnt_reg >= div_lim) begin
         div_cnt_next = 10'h000;
         tick_next    = 1'b1;
      end
   end

   // lowest pending idle channel wins; a gained start holds the sampler
   // one more converter clock, so nothing else may start on that tick
   always @* begin
      grant_any  = 1'b0;
      grant_chan = 2'h0;
      accept_vec = 4'h0;
      if (tick_next && !gain_hold_reg) begin // R14
         if (ch_pend[0] && !ch_busy[0]) begin
            grant_any  = 1'b1;
            grant_chan = 2'h0;
         end else if (ch_pend[1] && !ch_busy[1]) begin
            grant_any  = 1'b1;
            grant_chan = 2'h1;
         end else if (ch_pend[2] && !ch_busy[2]) begin
            grant_any  = 1'b1;
            grant_chan = 2'h2;
         end else if (ch_pend[3] && !ch_busy[3]) begin
            grant_any  = 1'b1;
            grant_chan = 2'h3;
         end
      end
      if (grant_any) begin
         accept_vec = 4'h1 << grant_chan;
      end
   end

   // analogue mux selection for the granted channel
   always @* begin
      pos_next = {1'b0, ch_pos[4*grant_chan +: 4]}; // R06
      neg_next = `ADCM_NSEL_INTGND;
      case (ch_mode[2*grant_chan +: 2])
         `ADCM_MODE_DIFF: begin
            pos_next = {1'b0, ch_pos[4*grant_chan +: 4]};
            if (ch_neg[3*grant_chan +: 3] == `ADCM_NEG_PADGND) begin
               neg_next = `ADCM_NSEL_PADGND; // R11
            end else if (ch_neg[3*grant_chan +: 3] == `ADCM_NEG_INTGND) begin
               neg_next = `ADCM_NSEL_INTGND; // R11
            end else begin
               // only pins 0..3; higher codes fall back to ground
               neg_next = {2'b00, ch_neg[3*grant_chan +: 2]}; // R01
               if (ch_neg[3*grant_chan + 2]) begin
                  neg_next = `ADCM_NSEL_INTGND;
               end
            end
         end
         `ADCM_MODE_DIFFG: begin
            if (ch_neg[3*grant_chan +: 3] == `ADCM_NEG_PADGND) begin
               neg_next = `ADCM_NSEL_PADGND; // R11
            end else if (ch_neg[3*grant_chan +: 3] == `ADCM_NEG_INTGND) begin
               neg_next = `ADCM_NSEL_INTGND; // R11
            end else if (ch_neg[3*grant_chan + 2]) begin
               neg_next = `ADCM_NSEL_INTGND;
            end else begin
               // the gained path reaches pins 4..7 only
               neg_next = `ADCM_NSEL_GRP_HI | {2'b00, ch_neg[3*grant_chan +: 2]}; // R02
            end
         end
         `ADCM_MODE_SE: begin
            if (ctrl_reg[`ADCM_CTRL_SIGNED]) begin
               neg_next = `ADCM_NSEL_INTGND; // R07
            end else begin
               neg_next = `ADCM_NSEL_HALFREF; // R08
            end
         end
         `ADCM_MODE_INT: begin
            // out-of-range internal codes read internal ground
            if (ch_pos[4*grant_chan +: 4] > {1'b0, `ADCM_INT_MAX}) begin
               pos_next = `ADCM_PSEL_INT | {2'b00, `ADCM_INT_MAX};
            end else begin
               pos_next = `ADCM_PSEL_INT | {1'b0, ch_pos[4*grant_chan +: 4]}; // R09
            end
            if (ctrl_reg[`ADCM_CTRL_SIGNED]) begin
               neg_next = `ADCM_NSEL_INTGND; // R12
            end else begin
               neg_next = `ADCM_NSEL_HALFREF; // R08
            end
         end
         default: begin
            neg_next = `ADCM_NSEL_INTGND;
         end
      endcase
   end

   // global control and prescaler registers
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         ctrl_reg  <= `ADCM_CTRL_RST;
         presc_reg <= `ADCM_PRESC_RST;
      end else if (i_wr) begin
         if (i_addr == `ADCM_A_CTRL) begin
            ctrl_reg <= i_wdata[7:0];
         end
         if (i_addr == `ADCM_A_PRESC) begin
            presc_reg <= i_wdata[2:0];
         end
      end
   end

   // prescaler state and gain-stage hold
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         div_cnt_reg   <= 10'h000;
         gain_hold_reg <= 1'b0;
         o_conv_tick   <= 1'b0;
      end else begin
         div_cnt_reg <= div_cnt_next;
         o_conv_tick <= tick_next;
         if (tick_next) begin
            // the gain stage eats one converter clock before the sample
            gain_hold_reg <= grant_any && (ch_mode[2*grant_chan +: 2] == `ADCM_MODE_DIFFG); // R05
         end
      end
   end

   // start command and frozen selection toward the analogue side
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_start       <= 1'b0;
         o_start_chan  <= 2'h0;
         o_pos_sel     <= 5'h00;
         o_neg_sel     <= `ADCM_NSEL_INTGND;
         o_gain_en     <= 1'b0;
         o_gain_sel    <= 3'h0;
         o_res8        <= 1'b0;
         o_signed_mode <= 1'b0;
         o_ref_sel     <= 2'h0;
         o_core_en     <= 1'b0;
      end else begin
         o_start       <= grant_any; // R14
         o_core_en     <= ctrl_reg[`ADCM_CTRL_EN];
         o_signed_mode <= ctrl_reg[`ADCM_CTRL_SIGNED]; // R17
         o_ref_sel     <= ctrl_reg[`ADCM_CTRL_REF +: 2]; // R16
         // held until the next start so the core sees a steady selection
         if (grant_any) begin
            o_start_chan <= grant_chan;
            o_pos_sel    <= pos_next; // R23
            o_neg_sel    <= neg_next; // R23
            o_gain_en    <= (ch_mode[2*grant_chan +: 2] == `ADCM_MODE_DIFFG); // R05
            o_gain_sel   <= ch_gain[3*grant_chan +: 3]; // R04
            o_res8       <= ctrl_reg[`ADCM_CTRL_RES8]; // R20
         end
      end
   end

   // per-channel event pulse, interrupt and dma levels
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_chan_event <= 4'h0;
         o_chan_irq   <= 4'h0;
         o_chan_dma   <= 4'h0;
      end else begin
         o_chan_event <= done_vec; // R13
         o_chan_irq   <= ch_flag;
         o_chan_dma   <= ch_dma;
      end
   end

   // read data mux; unmapped words read zero
   always @* begin
      rdata_next  = 16'h0000;
      res_word_in = 16'h0000;
      // control pairs start at word 4, so pair index 2 is channel 0
      rd_ch       = i_addr[2:1] - 2'h2;
      case (i_addr)
         `ADCM_A_CTRL:   rdata_next = {8'h00, ctrl_reg};
         `ADCM_A_PRESC:  rdata_next = {13'h0000, presc_reg};
         `ADCM_A_START:  rdata_next = {12'h000, ch_pend};
         `ADCM_A_STATUS: rdata_next = {8'h00, ch_busy, ch_flag};
         default: begin
            if (i_addr >= `ADCM_A_RES0 && i_addr <= `ADCM_A_RES0 + 5'h03) begin
               rdata_next = ch_result[16*i_addr[1:0] +: 16];
            end else if (i_addr >= `ADCM_A_CHCTRL0 && i_addr < `ADCM_A_RES0) begin
               if (i_addr[0]) begin
                  res_word_in = {9'h000, ch_neg[3*rd_ch +: 3], ch_pos[4*rd_ch +: 4]};
               end else begin
                  res_word_in = {11'h000, ch_gain[3*rd_ch +: 3], ch_mode[2*rd_ch +: 2]};
               end
               rdata_next = res_word_in;
            end
         end
      endcase
   end

   // read data register, valid the cycle after the read strobe only
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_rdata <= 16'h0000;
      end else if (i_rd) begin
         o_rdata <= rdata_next;
      end else begin
         o_rdata <= 16'h0000;
      end
   end
endmodule

/* tb/adcm_chk_assertions.sv */
/*
 * timing and selection checks for the converter control block.
 * assumes binding onto adcm_top; holds for any prescaler setting.
 */
`timescale 1ns/10ps
module adcm_chk (
   input wire logic        i_ref_clk,
   input wire logic        i_rst,
   input wire logic [4:0]  i_addr,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [15:0] o_rdata,
   input wire logic        i_core_done,
   input wire logic        o_core_en,
   input wire logic        o_conv_tick,
   input wire logic        o_start,
   input wire logic [4:0]  o_pos_sel,
   input wire logic [3:0]  o_neg_sel,
   input wire logic        o_gain_en,
   input wire logic [2:0]  o_gain_sel,
   input wire logic        o_signed_mode,
   input wire logic [3:0]  o_chan_event
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   // starts ride ticks of an enabled core, one per converter clock
   a_start_tick: assert property (o_start |-> o_conv_tick && o_core_en)
      else $error("start outside an enabled tick");
   a_start_gap: assert property (o_start |=> !o_start [*3])
      else $error("two starts in one converter clock");
   // negative input groups per path
   a_plain_neg: assert property (o_start && !o_gain_en && o_neg_sel < 4'h8 |-> o_neg_sel < 4'h4)
      else $error("plain negative outside pins 0 to 3");
   a_gain_neg: assert property (o_start && o_gain_en |-> o_neg_sel inside {[4'h4:4'h9]})
      else $error("gained negative outside pins 4 to 7");
   a_gain_code: assert property (o_start && o_gain_en |-> o_gain_sel <= 3'h6)
      else $error("gain code beyond 64x");
   a_signed_gnd: assert property (o_start && o_signed_mode |-> o_neg_sel != 4'hA)
      else $error("half reference used in signed mode");
   a_int_neg: assert property (o_start && o_pos_sel >= 5'h10 |->
      o_neg_sel == (o_signed_mode ? 4'h9 : 4'hA) && o_pos_sel <= 5'h15 && !o_gain_en)
      else $error("internal source with wrong negative");
   // result events only follow a finished code
   a_event_cause: assert property (|o_chan_event |-> $past(i_core_done) || $past(i_core_done, 2))
      else $error("event without finished code");
   a_event_pulse: assert property (|o_chan_event |=> (o_chan_event & $past(o_chan_event)) == 4'h0)
      else $error("event longer than one cycle");
   a_rdata_idle: assert property (!i_rd |=> o_rdata == 16'h0000)
      else $error("read data outside read answer");
   // mode is one global bit, moved only by a control write
   a_mode_global: assert property ($changed(o_signed_mode) |-> $past(i_wr, 2) && $past(i_addr, 2) == 5'h00)
      else $error("mode changed without control write");
endmodule
bind adcm_top adcm_chk chk_u (.*);

/* tb/adcm_core_model.sv */
/*
 * behavioural converter core on the far side of the control block.
 * assumes selection outputs are valid in the cycle of each start.
 */
`timescale 1ns/10ps
module adcm_core_model (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_tick,
   input  wire logic        i_start,
   input  wire logic [1:0]  i_chan,
   input  wire logic        i_res8,
   input  wire logic        i_gain,
   input  wire logic [47:0] i_codes,
   output logic             o_done = 1'b0,
   output logic [1:0]       o_chan = 2'h0,
   output logic [11:0]      o_data = 12'h000
);
   int left_q [4];
   // one code per clock, lowest channel first; idle bus toggles
   always @(posedge i_clk) begin : step
      logic sent;
      sent = 1'b0;
      o_done <= 1'b0;
      o_chan <= ~o_chan;
      o_data <= ~o_data;
      for (int k = 0; k < 4; k++) begin
         if (i_rst) begin
            left_q[k] = 0;
         end else if (left_q[k] == 1 && !sent) begin
            sent = 1'b1;
            left_q[k] = 0;
            o_done <= 1'b1;
            o_chan <= 2'(k);
            o_data <= i_codes[12 * k +: 12];
         end else if (left_q[k] > 1 && i_tick) begin
            left_q[k] = left_q[k] - 1;
         end
      end
      // a new start every tick; gain adds one tick
      if (!i_rst && i_start)
         left_q[i_chan] = (i_res8 ? 5 : 7) + int'(i_gain);
   end
endmodule

/* tb/testbench.sv */
/*
 * self-checking bench for the converter control block.
 * assumes the core model on the far side and a 40 MHz reference clock.
 */
`timescale 1ns/10ps
module testbench;
   logic        i_ref_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_core_done;
   logic        o_core_en, o_conv_tick, o_start, o_gain_en, o_res8, o_signed_mode;
   logic [1:0]  i_core_chan, o_start_chan, o_ref_sel;
   logic [2:0]  o_gain_sel;
   logic [3:0]  i_chan_trig = 0, o_neg_sel, o_chan_event, o_chan_irq, o_chan_dma;
   logic [4:0]  i_addr = 0, o_pos_sel;
   logic [11:0] i_core_data;
   logic [15:0] i_wdata = 0, o_rdata;
   logic [47:0] codes = 0;
   int          bad_count = 0, samples_checked = 0;
   adcm_top dut_u (.*);
   adcm_core_model core_u (.i_clk(i_ref_clk), .i_rst(i_rst), .i_tick(o_conv_tick), .i_start(o_start),
      .i_chan(o_start_chan), .i_res8(o_res8), .i_gain(o_gain_en), .i_codes(codes),
      .o_done(i_core_done), .o_chan(i_core_chan), .o_data(i_core_data));
   initial forever #12.5 i_ref_clk = ~i_ref_clk;
   task automatic final_report;
      if (bad_count == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(string n, logic [15:0] g, logic [15:0] e);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // one-cycle strobes launched just after an edge
   task automatic wr(logic [4:0] a, logic [15:0] d);
      @(posedge i_ref_clk) i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_ref_clk) i_wr <= 1'b0;
   endtask
   task automatic rd(logic [4:0] a, logic [15:0] e, string n);
      @(posedge i_ref_clk) i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_ref_clk) i_rd <= 1'b0;
      #1 chk(n, o_rdata, e);
   endtask
   // bounded wait on a start or a channel flag
   task automatic await(bit on_start, int ch);
      bit ev = 1'b0;
      for (int i = 0; i < 200; i++) begin
         @(posedge i_ref_clk) #1;
         if (on_start ? o_start === 1'b1 : o_chan_irq[ch] === 1'b1) begin
            if (!on_start)
               chk("event pulse", 16'(ev), 16'h0001);
            return;
         end
         ev = ev | (o_chan_event[ch] === 1'b1);
      end
      bad_count++;
      final_report;
   endtask
   task automatic setc(int ch, logic [7:0] ctl, logic [7:0] mx, logic [11:0] code);
      codes[12 * ch +: 12] = code;
      wr(5'h04 + 5'(2 * ch), {8'h00, ctl});
      wr(5'h05 + 5'(2 * ch), {8'h00, mx});
   endtask
   task automatic conv(int ch, logic [7:0] ctl, logic [7:0] mx, logic [11:0] code, logic [4:0] ep,
                       logic [3:0] en, logic [15:0] er);
      setc(ch, ctl, mx, code);
      wr(5'h02, 16'h0001 << ch);
      await(1'b1, ch);
      chk("positive select", 16'(o_pos_sel), 16'(ep));
      chk("negative select", 16'(o_neg_sel), 16'(en));
      chk("start channel", 16'(o_start_chan), 16'(ch));
      chk("gain enable", 16'(o_gain_en), 16'(ctl[1:0] == 2'h3));
      if (ctl[1:0] == 2'h3)
         chk("gain code", 16'(o_gain_sel), 16'(ctl[4:2]));
      await(1'b0, ch);
      chk("dma pending", 16'(o_chan_dma[ch]), 16'h0001);
      rd(5'h0C + 5'(ch), er, "result");
      wr(5'h03, 16'h000F);
      #1 chk("dma after read", 16'(o_chan_dma[ch]), 16'h0000);
   endtask
   task automatic t_reset;
      #1 chk("reset negative", 16'(o_neg_sel), 16'h0009);
      rd(5'h00, 16'h0000, "control");
      wr(5'h1F, 16'hFFFF);
      rd(5'h1F, 16'h0000, "unmapped");
   endtask
   task automatic t_diff;
      wr(5'h00, 16'h0003); // signed mode before differential work
      conv(0, 8'h02, 8'h25, 12'h800, 5'h05, 4'h2, 16'hF800);
      for (int g = 0; g < 7; g++)
         conv(1, 8'(3 + 4 * g), 8'h19, 12'h7FF, 5'h09, 4'h5, 16'h07FF);
      conv(2, 8'h02, 8'h43, 12'h001, 5'h03, 4'h8, 16'h0001);
      conv(2, 8'h03, 8'h53, 12'h001, 5'h03, 4'h9, 16'h0001);
      rd(5'h07, 16'h0019, "channel 1 mux");
      rd(5'h08, 16'h0003, "channel 2 control");
   endtask
   task automatic t_single;
      conv(3, 8'h01, 8'h0F, 12'hFFF, 5'h0F, 4'h9, 16'hFFFF);
      wr(5'h00, 16'h0007);
      conv(3, 8'h01, 8'h0F, 12'h080, 5'h0F, 4'h9, 16'hFF80);
      chk("resolution", 16'(o_res8), 16'h0001);
      wr(5'h00, 16'h0001);
      conv(3, 8'h01, 8'h0F, 12'hFFF, 5'h0F, 4'hA, 16'h0FFF);
      wr(5'h00, 16'h0009);
      conv(3, 8'h01, 8'h0F, 12'hABC, 5'h0F, 4'hA, 16'hABC0);
   endtask
   task automatic t_internal;
      wr(5'h00, 16'h0003);
      // sources taken as enabled by the far side
      for (int n = 0; n < 6; n++)
         conv(0, 8'h00, 8'(n), 12'h123, 5'(16 + n), 4'h9, 16'h0123);
      wr(5'h00, 16'h0001);
      conv(0, 8'h00, 8'h01, 12'h456, 5'h11, 4'hA, 16'h0456);
   endtask
   // two channels triggered in one cycle share the pipeline
   task automatic t_parallel;
      wr(5'h00, 16'h0003);
      setc(1, 8'h01, 8'h01, 12'h111);
      setc(2, 8'h01, 8'h02, 12'h222);
      @(posedge i_ref_clk) i_chan_trig <= 4'h6;
      @(posedge i_ref_clk) i_chan_trig <= 4'h0;
      await(1'b0, 1);
      await(1'b0, 2);
      rd(5'h0D, 16'h0111, "result 1");
      rd(5'h0E, 16'h0222, "result 2");
      rd(5'h0C, 16'h0456, "result 0");
      wr(5'h03, 16'h000F);
   endtask
   task automatic t_refs;
      for (int r = 0; r < 4; r++) begin
         wr(5'h00, 16'(r << 4));
         repeat (2) @(posedge i_ref_clk);
         #1 chk("reference", 16'(o_ref_sel), 16'(r));
      end
   endtask
   initial begin
      repeat (4) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      t_reset;
      t_diff;
      t_single;
      t_internal;
      t_parallel;
      t_refs;
      final_report;
   end
endmodule
